// ---- verification/itp_checker_properties.sv ----
/* port checker for itp_top.
   assumes one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
`include "itp_consts.vh"
module itp_checker (
   // clock, reset, modes
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic host_ts_en,
   input wire logic event_mode_en,
   input wire logic timeout_fix_en,
   // stream and stamps
   input wire logic rx_valid,
   input wire logic rx_sop,
   input wire logic rx_preamble_ok,
   input wire logic ts_req,
   input wire logic ts_ack,
   input wire logic dma_valid,
   input wire logic dma_sop,
   input wire logic [63:0] dma_ts,
   input wire logic dma_ts_valid,
   input wire logic evt_valid,
   input wire logic port_locked
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence s_bad_sop; rx_valid && rx_sop && !rx_preamble_ok; endsequence
   sequence s_sop_out; dma_valid && dma_sop; endsequence
   a_bad_no_req: assert property (s_bad_sop |=> !ts_req)
      else $error("request after bad preamble");
   a_req_cause: assert property (ts_req |-> $past(rx_valid && rx_sop))
      else $error("request without sop");
   a_evt_push: assert property (event_mode_en && ts_ack && !evt_valid |-> ##[1:2] evt_valid)
      else $error("event entry missing");
   a_host_ts: assert property ((host_ts_en ##0 s_sop_out) |-> dma_ts_valid || dma_ts == `ITP_TS_INVALID)
      else $error("host stamp missing");
   a_off_no_ts: assert property ((!host_ts_en ##0 s_sop_out) |-> !dma_ts_valid)
      else $error("stamp while disabled");
   a_ts_sane: assert property ((s_sop_out ##0 dma_ts_valid) |-> dma_ts != `ITP_TS_INVALID)
      else $error("valid flag on invalid stamp");
   a_lock_hold: assert property (port_locked && host_ts_en && !timeout_fix_en && !ts_ack |=> port_locked)
      else $error("lock cleared itself");
   a_fix_release: assert property (timeout_fix_en && port_locked |-> ##[1:3] !port_locked)
      else $error("lock kept with fix");
endmodule
bind itp_top itp_checker i_chk (
   .ref_clk(ref_clk),
   .srst(srst),
   .host_ts_en(host_ts_en),
   .event_mode_en(event_mode_en),
   .timeout_fix_en(timeout_fix_en),
   .rx_valid(rx_valid),
   .rx_sop(rx_sop),
   .rx_preamble_ok(rx_preamble_ok),
   .ts_req(ts_req),
   .ts_ack(ts_ack),
   .dma_valid(dma_valid),
   .dma_sop(dma_sop),
   .dma_ts(dma_ts),
   .dma_ts_valid(dma_ts_valid),
   .evt_valid(evt_valid),
   .port_locked(port_locked)
);
`default_nettype wire

// ---- verification/itp_top_test.sv ----
/* bench for itp_top with the time unit model.
   assumes itp_checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`include "itp_consts.vh"
module itp_top_test;
   logic ref_clk = 1'h0, srst = 1'h1, host_ts_en = 1'h0, event_mode_en = 1'h0, timeout_fix_en = 1'h0;
   logic rx_valid = 1'h0, rx_sop = 1'h1, rx_eop = 1'h1, rx_preamble_ok = 1'h1, dma_ready = 1'h1, evt_pop = 1'h0;
   logic rx_ready, ts_req, ts_ack, dma_valid, dma_sop, dma_eop, dma_ts_valid, evt_valid, evt_overflow, port_locked;
   logic [15:0] match_etype = 16'h88F7, rx_etype = 16'h0800;
   logic [31:0] rx_data = 32'h0, dma_data;
   logic [63:0] ts_value, dma_ts, evt_ts, last_ts;
   logic [7:0] tsu_delay = 8'h28;
   int fails = 0;
   int num_checks = 0;
   itp_top i_dut (
      .ref_clk(ref_clk), .srst(srst), .host_ts_en(host_ts_en), .event_mode_en(event_mode_en),
      .timeout_fix_en(timeout_fix_en), .match_etype(match_etype),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop),
      .rx_preamble_ok(rx_preamble_ok), .rx_etype(rx_etype),
      .ts_req(ts_req), .ts_ack(ts_ack), .ts_value(ts_value),
      .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data), .dma_sop(dma_sop), .dma_eop(dma_eop),
      .dma_ts(dma_ts), .dma_ts_valid(dma_ts_valid),
      .evt_valid(evt_valid), .evt_pop(evt_pop), .evt_ts(evt_ts), .evt_overflow(evt_overflow),
      .port_locked(port_locked)
   );
   itp_tsu_model i_tsu (
      .ref_clk(ref_clk), .srst(srst), .ts_req(ts_req), .tsu_delay(tsu_delay),
      .ts_ack(ts_ack), .ts_value(ts_value), .last_ts(last_ts)
   );
   task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // settled sampling, a run-out limit counts as a mismatch
   task until_hi(input logic evt);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while ((evt ? evt_valid : dma_valid) !== 1'h1 && n < 400);
      if ((evt ? evt_valid : dma_valid) !== 1'h1) fails++;
   endtask
   // rx_ready lags the fifo by one cycle: offer only once room is seen
   task send(input logic [15:0] et, input logic ok);
      do begin
         @(posedge ref_clk);
         #1;
      end while (rx_ready !== 1'h1);
      @(posedge ref_clk);
      rx_valid <= 1'h1;
      rx_etype <= et;
      rx_preamble_ok <= ok;
      rx_data <= rx_data + 32'h1;
      @(posedge ref_clk);
      rx_valid <= 1'h0;
   endtask
   task t_host;
      host_ts_en <= 1'h1;
      send(16'h0800, 1'h1);
      until_hi(1'b0);
      chk("dma_ts_valid", dma_ts_valid, 1'h1);
      chk("dma_ts", dma_ts, last_ts);
      chk("dma_data", dma_data, rx_data);
      chk("dma_sop_eop", {dma_sop, dma_eop}, 2'h3);
      @(posedge ref_clk);
      host_ts_en <= 1'h0;
      tsu_delay <= 8'h1;
   endtask
   task t_event;
      event_mode_en <= 1'h1;
      send(16'h88F7, 1'h1);
      until_hi(1'b1);
      chk("evt_ts", evt_ts, last_ts);
      @(posedge ref_clk);
      evt_pop <= 1'h1;
      @(posedge ref_clk);
      evt_pop <= 1'h0;
      send(16'h0800, 1'h1);
      repeat (60) @(posedge ref_clk);
      chk("evt_valid", evt_valid, 1'h0);
      // nine entries into eight slots
      repeat (9) send(16'h88F7, 1'h1);
      repeat (10) @(posedge ref_clk);
      chk("evt_overflow", evt_overflow, 1'h1);
      event_mode_en <= 1'h0;
   endtask
   task t_lost;
      host_ts_en <= 1'h1;
      timeout_fix_en <= 1'h1;
      send(16'h0800, 1'h0);
      until_hi(1'b0);
      chk("dma_ts_valid", dma_ts_valid, 1'h0);
      chk("dma_ts", dma_ts, `ITP_TS_INVALID);
      @(posedge ref_clk);
      timeout_fix_en <= 1'h0;
      send(16'h0800, 1'h0);
      repeat (300) @(posedge ref_clk);
      chk("port_locked", port_locked, 1'h1);
      chk("dma_valid", dma_valid, 1'h0);
      srst <= 1'h1;
      repeat (5) @(posedge ref_clk);
      srst <= 1'h0;
      host_ts_en <= 1'h0;
      send(16'h0800, 1'h0);
      until_hi(1'b0);
      chk("dma_ts_valid", dma_ts_valid, 1'h0);
      chk("port_locked", port_locked, 1'h0);
   endtask
   task t_full;
      @(posedge ref_clk);
      dma_ready <= 1'h0;
      rx_valid <= 1'h1;
      repeat (30) @(posedge ref_clk);
      chk("rx_ready", rx_ready, 1'h0);
      rx_valid <= 1'h0;
      dma_ready <= 1'h1;
      repeat (40) @(posedge ref_clk);
      chk("dma_valid", dma_valid, 1'h0);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'h0;
      @(posedge ref_clk);
      t_host;
      t_event;
      t_lost;
      t_full;
      summarize;
   end
   initial begin
      #200000;
      fails++;
      summarize;
   end
endmodule
`default_nettype wire

// ---- verification/itp_tsu_model.sv ----
/* time unit model: stamps a request tsu_delay+1 cycles after it is seen; a new request while busy restarts the count.
   assumes ref_clk only. */
`timescale 1ns/1ps
`default_nettype none
module itp_tsu_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // request and answer
   input wire logic ts_req,
   input wire logic [7:0] tsu_delay,
   output logic ts_ack,
   output logic [63:0] ts_value,
   output logic [63:0] last_ts
);
   logic [7:0] cnt;
   logic busy;
   always @(posedge ref_clk) begin
      ts_ack <= 1'h0;
      ts_value <= ~ts_value;
      cnt <= cnt - 8'h1;
      if (srst) begin
         busy <= 1'h0;
         ts_value <= 64'h0;
         last_ts <= 64'h0;
      end else if (ts_req) begin
         busy <= 1'h1;
         cnt <= tsu_delay;
      end else if (busy && cnt == 8'h0) begin
         busy <= 1'h0;
         ts_ack <= 1'h1;
         ts_value <= last_ts + 64'h1000;
         last_ts <= last_ts + 64'h1000;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/itp_consts.vh ----
/*
 constants for the ingress timestamp path: widths, FIFO depth, timeout counts.
 assumes inclusion by itp_top.v and two of the three verification files, not by itp_fifo.v.
*/
`ifndef ITP_CONSTS_VH
`define ITP_CONSTS_VH
`define ITP_DATA_W 32
`define ITP_TS_W 64
`define ITP_ETYPE_W 16
`define ITP_FIFO_DEPTH 8
`define ITP_FIFO_AW 3
`define ITP_TS_TIMEOUT_NS 2560
`define ITP_CLK_PERIOD_NS 10
`define ITP_TS_TIMEOUT_CYC (`ITP_TS_TIMEOUT_NS / `ITP_CLK_PERIOD_NS)
`define ITP_TIMEOUT_W 9
`define ITP_TS_INVALID 64'hFFFF_FFFF_FFFF_FFFF
`define ITP_ETYPE_RST 16'h88F7
`endif

// ---- verilog/itp_fifo.v ----
/*
 synchronous FIFO with parameterised width and depth, valid/ready both sides.
 assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module itp_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // clock and reset
   input wire ref_clk,
   input wire srst,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire do_wr;
   wire do_rd;
   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_r];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   always @(posedge ref_clk) begin
      if (do_wr) begin
         mem[wr_ptr_r] <= in_data;
      end
   end
   always @(posedge ref_clk) begin
      if (srst) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count_r <= count_r + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/itp_top.v ----
/*
 ingress timestamp path: port FIFO plus event FIFO fed by a time sync unit.
 assumes synchronous packet word stream with sop/eop, stamp answer from the
 time sync unit as a one-cycle pulse, all on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itp_consts.vh"
module itp_top (
   // clock and reset
   input wire ref_clk,
   input wire srst,
   // mode and configuration
   input wire host_ts_en,
   input wire event_mode_en,
   input wire timeout_fix_en,
   input wire [`ITP_ETYPE_W-1:0] match_etype,
   // receive stream from the ethernet_switch_subsystem port
   input wire rx_valid,
   output reg rx_ready,
   input wire [`ITP_DATA_W-1:0] rx_data,
   input wire rx_sop,
   input wire rx_eop,
   input wire rx_preamble_ok,
   input wire [`ITP_ETYPE_W-1:0] rx_etype,
   // time_sync_unit request and answer
   output reg ts_req,
   input wire ts_ack,
   input wire [`ITP_TS_W-1:0] ts_value,
   // payload toward host DMA
   output reg dma_valid,
   input wire dma_ready,
   output reg [`ITP_DATA_W-1:0] dma_data,
   output reg dma_sop,
   output reg dma_eop,
   output reg [`ITP_TS_W-1:0] dma_ts,
   output reg dma_ts_valid,
   // event FIFO read by the host, and the port lock flag
   output reg evt_valid,
   input wire evt_pop,
   output reg [`ITP_TS_W-1:0] evt_ts,
   output reg evt_overflow,
   output reg port_locked
);
   // =====================================================
   // state encodings
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_PASS = 3'b100;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [`ITP_TIMEOUT_W-1:0] wait_cnt_r;
   reg [`ITP_TS_W-1:0] ts_hold_r;
   reg ts_hold_ok_r;
   // =====================================================
   // port FIFO
   wire pf_in_ready;
   wire pf_out_valid;
   wire [`ITP_DATA_W+1:0] pf_out_data;
   wire pf_pop;
   wire rx_take;
   assign rx_take = rx_valid && pf_in_ready;
   itp_fifo #(
      .WIDTH(`ITP_DATA_W + 2),
      .DEPTH(`ITP_FIFO_DEPTH),
      .AW(`ITP_FIFO_AW)
   ) u_port_fifo (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(rx_valid),
      .in_ready(pf_in_ready),
      .in_data({rx_sop, rx_eop, rx_data}),
      .out_valid(pf_out_valid),
      .out_ready(pf_pop),
      .out_data(pf_out_data)
   );
   // back-pressure toward the port
   always @(posedge ref_clk) begin
      if (srst) begin
         rx_ready <= 1'b0;
      end else begin
         rx_ready <= pf_in_ready;
      end
   end
   // =====================================================
   // stamp request
   wire want_req;
   assign want_req = rx_take && rx_sop && rx_preamble_ok &&
                     (host_ts_en || (event_mode_en && rx_etype == match_etype));
   always @(posedge ref_clk) begin
      if (srst) begin
         ts_req <= 1'b0;
      end else begin
         ts_req <= want_req;
      end
   end
   // =====================================================
   // event FIFO for host reads
   wire ev_in_ready;
   wire ev_out_valid;
   wire [`ITP_TS_W-1:0] ev_out_data;
   wire ev_push;
   assign ev_push = ts_ack && event_mode_en;
   itp_fifo #(
      .WIDTH(`ITP_TS_W),
      .DEPTH(`ITP_FIFO_DEPTH),
      .AW(`ITP_FIFO_AW)
   ) u_event_fifo (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(ev_push),
      .in_ready(ev_in_ready),
      .in_data(ts_value),
      .out_valid(ev_out_valid),
      .out_ready(evt_pop && evt_valid),
      .out_data(ev_out_data)
   );
   always @(posedge ref_clk) begin
      if (srst) begin
         evt_valid <= 1'b0;
         evt_ts <= {`ITP_TS_W{1'b0}};
         evt_overflow <= 1'b0;
      end else begin
         evt_valid <= ev_out_valid && !(evt_pop && evt_valid);
         evt_ts <= ev_out_data;
         if (ev_push && !ev_in_ready) begin
            evt_overflow <= 1'b1;
         end
      end
   end
   // =====================================================
   // stamp hold for host mode
   always @(posedge ref_clk) begin
      if (srst) begin
         ts_hold_r <= {`ITP_TS_W{1'b0}};
         ts_hold_ok_r <= 1'b0;
      end else if (ts_ack && host_ts_en) begin
         ts_hold_r <= ts_value;
         ts_hold_ok_r <= 1'b1;
      end else if (pf_pop && pf_out_data[`ITP_DATA_W+1]) begin
         // stamp consumed when the packet head leaves
         ts_hold_ok_r <= 1'b0;
      end
   end
   // =====================================================
   // port release state machine
   wire head_sop;
   wire head_eop;
   wire timed_out;
   assign head_sop = pf_out_data[`ITP_DATA_W+1];
   assign head_eop = pf_out_data[`ITP_DATA_W];
   assign timed_out = timeout_fix_en &&
                      (wait_cnt_r >= `ITP_TS_TIMEOUT_CYC - 1);
   assign pf_pop = (state_r == ST_PASS) && pf_out_valid && (!dma_valid || dma_ready);
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (pf_out_valid && head_sop) begin
               state_nxt = host_ts_en ? ST_WAIT : ST_PASS;
            end else if (pf_out_valid) begin
               state_nxt = ST_PASS;
            end
         end
         ST_WAIT: begin
            if (ts_hold_ok_r || timed_out || !host_ts_en) begin
               state_nxt = ST_PASS;
            end
         end
         ST_PASS: begin
            if (pf_pop && head_eop) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end
   always @(posedge ref_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         wait_cnt_r <= {`ITP_TIMEOUT_W{1'b0}};
         port_locked <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_WAIT && state_nxt == ST_WAIT) begin
            wait_cnt_r <= wait_cnt_r + 1'b1;
         end else begin
            wait_cnt_r <= {`ITP_TIMEOUT_W{1'b0}};
         end
         port_locked <= (state_r == ST_WAIT) && (wait_cnt_r >= `ITP_TS_TIMEOUT_CYC - 1);
      end
   end
   // =====================================================
   // DMA output register
   always @(posedge ref_clk) begin
      if (srst) begin
         dma_valid <= 1'b0;
         dma_data <= {`ITP_DATA_W{1'b0}};
         dma_sop <= 1'b0;
         dma_eop <= 1'b0;
         dma_ts <= {`ITP_TS_W{1'b0}};
         dma_ts_valid <= 1'b0;
      end else begin
         if (pf_pop) begin
            dma_valid <= 1'b1;
            dma_data <= pf_out_data[`ITP_DATA_W-1:0];
            dma_sop <= head_sop;
            dma_eop <= head_eop;
            if (head_sop) begin
               dma_ts <= (host_ts_en && ts_hold_ok_r) ? ts_hold_r : `ITP_TS_INVALID;
               dma_ts_valid <= host_ts_en && ts_hold_ok_r;
            end
         end else if (dma_ready) begin
            dma_valid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire
